/* File: logic/power_stage_pkg.sv */
// Constants for the power stage synchronisation, clock and output block
package power_stage_pkg;
	// ------------------------------------------------------------
	// Geometry and register map (word index inside a unit window)
	// ------------------------------------------------------------
	localparam int unsigned UNITS        = 3;
	localparam logic [1:0]  UNIT_LAST    = 2'h2;
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_CFG      = 4'h1;
	localparam logic [3:0]  REG_SOC      = 4'h2;
	localparam logic [3:0]  REG_SAH      = 4'h3;
	localparam logic [3:0]  REG_SAL      = 4'h4;
	localparam logic [3:0]  REG_RAH      = 4'h5;
	localparam logic [3:0]  REG_RAL      = 4'h6;
	localparam logic [3:0]  REG_SBH      = 4'h7;
	localparam logic [3:0]  REG_SBL      = 4'h8;
	localparam logic [3:0]  REG_RBH      = 4'h9;
	localparam logic [3:0]  REG_RBL      = 4'ha;
	localparam logic [3:0]  REG_IMSK     = 4'hb;
	localparam logic [3:0]  REG_IFLG     = 4'hc;
	localparam logic [3:0]  REG_STAT     = 4'hd;
	localparam logic [7:0]  RESET_BYTE   = 8'h00;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_RUN     = 0;
	localparam int unsigned CTRL_AUTORUN = 2;
	localparam int unsigned CTRL_PRE_LSB = 6;
	localparam int unsigned CFG_CLKSEL   = 1;
	localparam int unsigned CFG_MODE_LSB = 3;
	localparam int unsigned SOC_PIN0     = 0;
	localparam int unsigned SOC_PIN2     = 1;
	localparam int unsigned SOC_PIN1     = 2;
	localparam int unsigned SOC_PIN3     = 3;
	localparam int unsigned SOC_TRIG_LSB = 4;
	localparam int unsigned SOC_OUT2_SEL = 6;
	localparam int unsigned SOC_OUT3_SEL = 7;
	localparam int unsigned IRQ_EC       = 0;
	localparam int unsigned IRQ_CAPTURE_IRQ     = 1;
	// ------------------------------------------------------------
	// Modes, trigger codes and prescaler terminal counts
	// ------------------------------------------------------------
	localparam logic [1:0]  MODE_CENTRED = 2'h3;
	localparam logic [1:0]  TRIG_LEAD_A  = 2'h0;
	localparam logic [1:0]  TRIG_TRAIL_A = 2'h1;
	localparam logic [1:0]  TRIG_LEAD_B  = 2'h2;
	localparam logic [1:0]  TRIG_TRAIL_B = 2'h3;
	localparam logic [7:0]  PRE_TERM_1   = 8'h00;
	localparam logic [7:0]  PRE_TERM_4   = 8'h03;
	localparam logic [7:0]  PRE_TERM_32  = 8'h1f;
	localparam logic [7:0]  PRE_TERM_256 = 8'hff;
endpackage

/* File: logic/power_stage_sync_clock_config.sv */
// Run chain, clock prescaler, interrupt flags, pin routing and compare registers
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/10ps

module power_stage_sync_clock_config (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        io_tick_i,
	input  wire logic        pll_tick_i,
	input  wire logic [2:0]  gen_a_i,
	input  wire logic [2:0]  gen_b_i,
	input  wire logic [2:0]  match_sa_i,
	input  wire logic [2:0]  match_ra_i,
	input  wire logic [2:0]  match_sb_i,
	input  wire logic [2:0]  match_rb_i,
	input  wire logic [2:0]  count_down_i,
	input  wire logic [2:0]  fault_part_a_i,
	input  wire logic [2:0]  fault_part_b_i,
	input  wire logic [2:0]  retrigger_i,
	input  wire logic [2:0]  capture_i,
	input  wire logic [2:0]  sync_error_i,
	input  wire logic [2:0]  halt_fault_i,
	input  wire logic [2:0]  halt_fault_en_i,
	output logic      [2:0]  unit_run_o,
	output logic      [2:0]  unit_tick_o,
	output logic      [2:0]  converter_trigger_o,
	output logic      [2:0]  waveform_out0_o,
	output logic      [2:0]  waveform_out1_o,
	output logic             waveform_out2_o,
	output logic             waveform_out3_o,
	output logic      [2:0]  pin0_enable_o,
	output logic      [2:0]  pin1_enable_o,
	output logic             pin2_enable_o,
	output logic             pin3_enable_o,
	output logic      [35:0] compare_set_a_o,
	output logic      [35:0] compare_reset_a_o,
	output logic      [35:0] compare_set_b_o,
	output logic      [47:0] compare_reset_b_o,
	output logic      [5:0]  irq_vector_o
);
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [7:0]  ctrl_q [3], ctrl_d [3]; // Control: prescale, autorun, run
	logic [7:0]  cfg_q  [3], cfg_d  [3]; // Config: clock select, mode
	logic [7:0]  soc_q  [3], soc_d  [3]; // Sync and output config
	logic [1:0]  imsk_q [3], imsk_d [3]; // Interrupt enables
	logic [1:0]  iflg_q [3], iflg_d [3]; // Sticky interrupt flags
	logic [11:0] csa_q  [3], csa_d  [3]; // Compare set A
	logic [11:0] cra_q  [3], cra_d  [3]; // Compare reset A
	logic [11:0] csb_q  [3], csb_d  [3]; // Compare set B
	logic [15:0] crb_q  [3], crb_d  [3]; // Compare reset B with flank width field
	logic [7:0]  temp_q, temp_d;         // Shared staged high byte
	logic        ack_q, ack_d;           // Bus answer cycle
	logic [31:0] rdata_q, rdata_d;       // Read data holding register
	logic [2:0]  run_q, run_d;           // Effective run state per unit
	logic [2:0]  run_bit;        // Next run bits after bus and faults
	logic [2:0]  auto_bit;       // Autorun bits
	logic [2:0]  slave;          // Autorun set, run clear
	logic [2:0]  fault7;         // Configured mode 7 fault per unit
	logic [1:0]  unit_sel;       // Addressed unit
	logic [3:0]  reg_sel;        // Addressed register
	logic        req;            // Any bus request
	logic        hit;            // Request lands on a mapped unit
	logic        wr_go;          // Write takes effect this cycle

	// Decode: byte address, one word per register, 16 words per unit
	assign req      = avs_read_i | avs_write_i;
	assign unit_sel = avs_address_i[7:6];
	assign reg_sel  = avs_address_i[5:2];
	assign hit      = (unit_sel <= power_stage_pkg::UNIT_LAST) && (avs_address_i[1:0] == 2'h0);
	assign wr_go    = avs_write_i & ack_q & hit;
	// One wait state: the slave answers at the second edge of a request
	assign avs_waitrequest_o = req & ~ack_q;
	assign avs_readdata_o    = rdata_q;

	// Position in the chain: unit n follows unit (n+2)%3
	function automatic int unsigned prv(input int unsigned n);
		prv = (n + 2) % 3;
	endfunction
	function automatic int unsigned nxt(input int unsigned n);
		nxt = (n + 1) % 3;
	endfunction

	// ------------------------------------------------------------
	// Register file, run chain and flags
	// ------------------------------------------------------------
	// Unrolled two hops so that an illegal all-autorun setting gives no loop
	always_comb begin
		ack_d   = req & ~ack_q;
		rdata_d = rdata_q;
		temp_d  = temp_q;
		for (int unsigned n = 0; n < 3; n++) begin
			ctrl_d[n] = ctrl_q[n];
			cfg_d[n]  = cfg_q[n];
			soc_d[n]  = soc_q[n];
			imsk_d[n] = imsk_q[n];
			iflg_d[n] = iflg_q[n];
			csa_d[n]  = csa_q[n];
			cra_d[n]  = cra_q[n];
			csb_d[n]  = csb_q[n];
			crb_d[n]  = crb_q[n];
			auto_bit[n] = ctrl_q[n][power_stage_pkg::CTRL_AUTORUN];
			slave[n]    = auto_bit[n] & ~ctrl_q[n][power_stage_pkg::CTRL_RUN];
			fault7[n]   = halt_fault_i[n] & halt_fault_en_i[n];
		end
		// Read capture on the first edge; reserved and write-only read zero
		if (avs_read_i && !ack_q) begin
			rdata_d = 32'h0000_0000;
			if (hit) begin
				unique case (reg_sel)
					power_stage_pkg::REG_CTRL: rdata_d[7:0] = ctrl_q[unit_sel];
					power_stage_pkg::REG_CFG:  rdata_d[7:0] = cfg_q[unit_sel];
					power_stage_pkg::REG_SOC:  rdata_d[7:0] = soc_q[unit_sel];
					power_stage_pkg::REG_IMSK: rdata_d[1:0] = imsk_q[unit_sel];
					power_stage_pkg::REG_IFLG: rdata_d[1:0] = iflg_q[unit_sel];
					power_stage_pkg::REG_STAT: rdata_d[0]   = run_q[unit_sel];
					default:                   rdata_d      = 32'h0000_0000;
				endcase
			end
		end
		// Writes take effect at the answering edge only
		if (wr_go) begin
			unique case (reg_sel)
				power_stage_pkg::REG_CTRL: ctrl_d[unit_sel] = avs_writedata_i[7:0];
				power_stage_pkg::REG_CFG:  cfg_d[unit_sel]  = avs_writedata_i[7:0];
				power_stage_pkg::REG_SOC:  soc_d[unit_sel]  = avs_writedata_i[7:0];
				power_stage_pkg::REG_IMSK: imsk_d[unit_sel] = avs_writedata_i[1:0];
				// High bytes only stage; the low byte loads both halves
				power_stage_pkg::REG_SAH, power_stage_pkg::REG_RAH,
				power_stage_pkg::REG_SBH, power_stage_pkg::REG_RBH: temp_d = avs_writedata_i[7:0];
				power_stage_pkg::REG_SAL: csa_d[unit_sel] = {temp_q[3:0], avs_writedata_i[7:0]};
				power_stage_pkg::REG_RAL: cra_d[unit_sel] = {temp_q[3:0], avs_writedata_i[7:0]};
				power_stage_pkg::REG_SBL: csb_d[unit_sel] = {temp_q[3:0], avs_writedata_i[7:0]};
				power_stage_pkg::REG_RBL: crb_d[unit_sel] = {temp_q, avs_writedata_i[7:0]};
				default: ;
			endcase
		end
		for (int unsigned n = 0; n < 3; n++) begin
			// Sticky flags: write one clears, a new event wins over the clear
			if (wr_go && reg_sel == power_stage_pkg::REG_IFLG && unit_sel == n[1:0]) begin
				iflg_d[n] = iflg_q[n] & ~avs_writedata_i[1:0];
			end
			if (match_rb_i[n]) begin
				iflg_d[n][power_stage_pkg::IRQ_EC] = 1'b1;
			end
			if (retrigger_i[n] | capture_i[n] | sync_error_i[n]) begin
				iflg_d[n][power_stage_pkg::IRQ_CAPTURE_IRQ] = 1'b1;
			end
		end
		// A master halts on its own fault or one forwarded by its slaves
		for (int unsigned n = 0; n < 3; n++) begin
			if (fault7[n]
			    || (slave[nxt(n)] && fault7[nxt(n)])
			    || (slave[nxt(n)] && slave[nxt(nxt(n))] && fault7[nxt(nxt(n))])) begin
				ctrl_d[n][power_stage_pkg::CTRL_RUN] = 1'b0;
			end
			run_bit[n] = ctrl_d[n][power_stage_pkg::CTRL_RUN];
		end
		// Run wins over autorun; a slave runs only while its source runs
		for (int unsigned n = 0; n < 3; n++) begin
			run_d[n] = run_bit[n]
			           | (ctrl_d[n][power_stage_pkg::CTRL_AUTORUN]
			              & (run_bit[prv(n)]
			                 | (ctrl_d[prv(n)][power_stage_pkg::CTRL_AUTORUN]
			                    & run_bit[prv(prv(n))])));
		end
	end

	// Register update for the bus and configuration state
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
			temp_q  <= power_stage_pkg::RESET_BYTE;
			run_q   <= 3'h0;
			for (int unsigned n = 0; n < 3; n++) begin
				ctrl_q[n] <= power_stage_pkg::RESET_BYTE;
				cfg_q[n]  <= power_stage_pkg::RESET_BYTE;
				soc_q[n]  <= power_stage_pkg::RESET_BYTE;
				imsk_q[n] <= 2'h0;
				iflg_q[n] <= 2'h0;
				csa_q[n]  <= 12'h000;
				cra_q[n]  <= 12'h000;
				csb_q[n]  <= 12'h000;
				crb_q[n]  <= 16'h0000;
			end
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
			temp_q  <= temp_d;
			run_q   <= run_d;
			ctrl_q  <= ctrl_d;
			cfg_q   <= cfg_d;
			soc_q   <= soc_d;
			imsk_q  <= imsk_d;
			iflg_q  <= iflg_d;
			csa_q   <= csa_d;
			cra_q   <= cra_d;
			csb_q   <= csb_d;
			crb_q   <= crb_d;
		end
	end

	// ------------------------------------------------------------
	// Per-unit prescaler, trigger and pin routing
	// ------------------------------------------------------------
	logic [7:0] pre_q [3], pre_d [3]; // Prescale counter
	logic [2:0] tick_q, tick_d;       // Divided unit clock enable
	logic [2:0] trig_q, trig_d;       // Converter trigger pulse
	logic [2:0] out0_q, out0_d;       // Output 0 level
	logic [2:0] out1_q, out1_d;       // Output 1 level
	logic [1:0] out23_q, out23_d;     // Unit 2 extra outputs

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_unit
			logic       src_tick;    // Selected source clock enable
			logic [7:0] term;        // Terminal count of prescaler
			logic [1:0] tsel;        // Trigger select
			logic       centred;     // Centre aligned mode
			assign src_tick = cfg_q[g][power_stage_pkg::CFG_CLKSEL] ? pll_tick_i : io_tick_i;
			assign tsel     = soc_q[g][power_stage_pkg::SOC_TRIG_LSB +: 2];
			assign centred  = cfg_q[g][power_stage_pkg::CFG_MODE_LSB +: 2] == power_stage_pkg::MODE_CENTRED;

			// Terminal count from the prescale code
			always_comb begin
				unique case (ctrl_q[g][power_stage_pkg::CTRL_PRE_LSB +: 2])
					2'h0: term = power_stage_pkg::PRE_TERM_1;
					2'h1: term = power_stage_pkg::PRE_TERM_4;
					2'h2: term = power_stage_pkg::PRE_TERM_32;
					2'h3: term = power_stage_pkg::PRE_TERM_256;
				endcase
			end

			// Counter restarts with the unit, so the first tick is aligned to the start
			always_comb begin
				pre_d[g]  = pre_q[g];
				tick_d[g] = 1'b0;
				if (!run_q[g]) begin
					pre_d[g] = 8'h00;
				end else if (src_tick) begin
					if (pre_q[g] >= term) begin
						pre_d[g]  = 8'h00;
						tick_d[g] = 1'b1;
					end else begin
						pre_d[g] = pre_q[g] + 8'h01;
					end
				end
			end

			// Converter trigger; centred mode uses RA only, codes 2 and 3 are silent
			always_comb begin
				trig_d[g] = 1'b0;
				if (centred) begin
					unique case (tsel)
						power_stage_pkg::TRIG_LEAD_A:  trig_d[g] = match_ra_i[g] & count_down_i[g];
						power_stage_pkg::TRIG_TRAIL_A: trig_d[g] = match_ra_i[g] & ~count_down_i[g];
						default:                       trig_d[g] = 1'b0;
					endcase
				end else begin
					unique case (tsel)
						power_stage_pkg::TRIG_LEAD_A:  trig_d[g] = match_sa_i[g];
						power_stage_pkg::TRIG_TRAIL_A: trig_d[g] = match_ra_i[g] | fault_part_a_i[g];
						power_stage_pkg::TRIG_LEAD_B:  trig_d[g] = match_sb_i[g];
						power_stage_pkg::TRIG_TRAIL_B: trig_d[g] = match_rb_i[g] | fault_part_b_i[g];
					endcase
				end
				out0_d[g] = gen_a_i[g];
				out1_d[g] = gen_b_i[g];
			end

			// Vector order: index 2k is capture, 2k+1 end of cycle, unit 2 first
			assign irq_vector_o[2 * (2 - g)]     = iflg_q[g][power_stage_pkg::IRQ_CAPTURE_IRQ] & imsk_q[g][power_stage_pkg::IRQ_CAPTURE_IRQ];
			assign irq_vector_o[2 * (2 - g) + 1] = iflg_q[g][power_stage_pkg::IRQ_EC] & imsk_q[g][power_stage_pkg::IRQ_EC];
			assign pin0_enable_o[g] = soc_q[g][power_stage_pkg::SOC_PIN0];
			assign pin1_enable_o[g] = soc_q[g][power_stage_pkg::SOC_PIN1];
			assign compare_set_a_o[12 * g +: 12]   = csa_q[g];
			assign compare_reset_a_o[12 * g +: 12] = cra_q[g];
			assign compare_set_b_o[12 * g +: 12]   = csb_q[g];
			assign compare_reset_b_o[16 * g +: 16] = crb_q[g];
		end
	endgenerate

	// Unit 2 output matrix for the two extra pins
	always_comb begin
		out23_d[0] = soc_q[2][power_stage_pkg::SOC_OUT2_SEL] ? gen_b_i[2] : gen_a_i[2];
		out23_d[1] = soc_q[2][power_stage_pkg::SOC_OUT3_SEL] ? gen_a_i[2] : gen_b_i[2];
	end
	assign pin2_enable_o = soc_q[2][power_stage_pkg::SOC_PIN2];
	assign pin3_enable_o = soc_q[2][power_stage_pkg::SOC_PIN3];

	// Output flops; one cycle of latency keeps the tick, trigger and waveform outputs glitch free
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_q  <= 3'h0;
			trig_q  <= 3'h0;
			out0_q  <= 3'h0;
			out1_q  <= 3'h0;
			out23_q <= 2'h0;
			for (int unsigned n = 0; n < 3; n++) begin
				pre_q[n] <= 8'h00;
			end
		end else begin
			tick_q  <= tick_d;
			trig_q  <= trig_d;
			out0_q  <= out0_d;
			out1_q  <= out1_d;
			out23_q <= out23_d;
			pre_q   <= pre_d;
		end
	end
	assign unit_run_o          = run_q;
	assign unit_tick_o         = tick_q;
	assign converter_trigger_o = trig_q;
	assign waveform_out0_o     = out0_q;
	assign waveform_out1_o     = out1_q;
	assign waveform_out2_o     = out23_q[0];
	assign waveform_out3_o     = out23_q[1];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_slave_starts_together: assert property (
		(!run_q[0] && run_d[0] && ctrl_q[1][power_stage_pkg::CTRL_AUTORUN] && !run_bit[1]
		 && !run_q[1]) |=> (run_q[0] && run_q[1]))
		else $error("slave did not start with master");
	a_follower_stops: assert property (
		($fell(run_q[0]) && slave[1] && $past(slave[1]) && !run_bit[2]) |-> !run_q[1])
		else $error("follower kept running");
	a_fault_halts_unit: assert property (
		fault7[2] |=> !ctrl_q[2][power_stage_pkg::CTRL_RUN] && !run_q[2])
		else $error("mode 7 fault did not halt unit");
	a_fault_back_prop: assert property (
		(fault7[2] && slave[2] && slave[1]) |=> !ctrl_q[0][power_stage_pkg::CTRL_RUN])
		else $error("slave fault not forwarded");
	a_div1_tick: assert property (
		(run_q[0] && ctrl_q[0][7:6] == 2'h0 && !cfg_q[0][power_stage_pkg::CFG_CLKSEL] && io_tick_i)
		|=> unit_tick_o[0])
		else $error("undivided tick missing");
	a_div4_gap: assert property (
		(unit_tick_o[0] && $stable(ctrl_q[0]) && ctrl_q[0][7:6] == 2'h1) |=> (!unit_tick_o[0])[*3])
		else $error("divide by four ticked too soon");
	a_ec_flag: assert property (
		match_rb_i[0] |=> iflg_q[0][power_stage_pkg::IRQ_EC])
		else $error("end of cycle flag lost");
	a_capture_irq_flag: assert property (
		(retrigger_i[0] || capture_i[0] || sync_error_i[0]) |=> iflg_q[0][power_stage_pkg::IRQ_CAPTURE_IRQ])
		else $error("capture flag lost");
	a_irq_gated: assert property (
		irq_vector_o[5] == (iflg_q[0][power_stage_pkg::IRQ_EC] && imsk_q[0][power_stage_pkg::IRQ_EC]))
		else $error("unit 0 end of cycle request wrong");
	a_centred_silent: assert property (
		(cfg_q[0][4:3] == power_stage_pkg::MODE_CENTRED && soc_q[0][5]) |=> !converter_trigger_o[0])
		else $error("centred mode trigger on silent code");
	a_out3_route: assert property (
		##1 waveform_out3_o == ($past(soc_q[2][7]) ? $past(gen_a_i[2]) : $past(gen_b_i[2])))
		else $error("output 3 routing wrong");
	a_compare_pair: assert property (
		(wr_go && reg_sel == power_stage_pkg::REG_SAL && unit_sel == 2'h1)
		|=> compare_set_a_o[23:12] == {$past(temp_q[3:0]), $past(avs_writedata_i[7:0])})
		else $error("compare pair not loaded together");

	c_master_slave_start: cover property (!run_q[0] && !run_q[1] ##1 run_q[0] && run_q[1]);
	c_fault_halt: cover property (run_q[0] && run_q[1] && fault7[2] ##1 !run_q[0]);
	c_irq_raised: cover property (irq_vector_o[4]);
	c_trigger_centred: cover property (converter_trigger_o[0] && cfg_q[0][4:3] == power_stage_pkg::MODE_CENTRED);
endmodule

/* File: test/sample_hold_model.sv */
// Far-side model: converter sample-and-hold and switch stage clock watcher
`timescale 1ns/10ps
module sample_hold_model (
	input  wire logic ref_clk_i,
	input  wire logic trigger_i,
	input  wire logic tick_i,
	output int        trig_cnt_o,
	output int        tick_cnt_o
);
	// ------------------------------------------------------------
	// Pulse counters
	// ------------------------------------------------------------
	// Both inputs are one-cycle pulses, so one sample per edge counts each once
	initial begin
		trig_cnt_o = 0;
		tick_cnt_o = 0;
		forever @(posedge ref_clk_i) begin
			if (trigger_i === 1'b1) trig_cnt_o++;
			if (tick_i === 1'b1) tick_cnt_o++;
		end
	end
endmodule

/* File: test/power_stage_sync_clock_config_tb.sv */
// Register-level testbench of the run chain, prescaler, irq, pin and compare block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module power_stage_sync_clock_config_tb;
	logic        ref_clk, rst_n, rd, wr, io_tick, pll_tick, wreq, out2, out3, pen2, pen3;
	logic [7:0]  addr, wdat;
	logic [31:0] rdata, q;
	logic [2:0]  gen_a, gen_b, down, hen, run, tick, trig, out0, out1, pen0, pen1;
	logic [2:0]  pls [0:9]; // Pulses: sa ra sb rb fault_a fault_b retrig capture_irq sync halt
	logic [35:0] csa, cra, csb;
	logic [47:0] crb;
	logic [5:0]  irq;
	int          mismatches, n_compared, tc, kc, tc_now, kc_now, e;
	int          sh [4] = '{0, 2, 5, 8}; // Divider shifts for codes 0..3

	power_stage_sync_clock_config i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i({24'h0, wdat}), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .io_tick_i(io_tick), .pll_tick_i(pll_tick), .gen_a_i(gen_a), .gen_b_i(gen_b),
		.match_sa_i(pls[0]), .match_ra_i(pls[1]), .match_sb_i(pls[2]), .match_rb_i(pls[3]), .count_down_i(down),
		.fault_part_a_i(pls[4]), .fault_part_b_i(pls[5]), .retrigger_i(pls[6]), .capture_i(pls[7]),
		.sync_error_i(pls[8]), .halt_fault_i(pls[9]), .halt_fault_en_i(hen), .unit_run_o(run),
		.unit_tick_o(tick), .converter_trigger_o(trig), .waveform_out0_o(out0), .waveform_out1_o(out1),
		.waveform_out2_o(out2), .waveform_out3_o(out3), .pin0_enable_o(pen0), .pin1_enable_o(pen1),
		.pin2_enable_o(pen2), .pin3_enable_o(pen3), .compare_set_a_o(csa), .compare_reset_a_o(cra),
		.compare_set_b_o(csb), .compare_reset_b_o(crb), .irq_vector_o(irq));
	sample_hold_model i_sh (.ref_clk_i(ref_clk), .trigger_i(trig[0]), .tick_i(tick[0]), .trig_cnt_o(tc_now),
		.tick_cnt_o(kc_now));

	// ------------------------------------------------------------
	// Clock, bus and pulse helpers
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Avalon access; waitrequest and read data are taken at the rising edge, before that edge's updates land
	task automatic bus(input logic w, input logic [1:0] u, input logic [3:0] i, input logic [7:0] d);
		@(posedge ref_clk);
		{addr, wr, rd, wdat} <= {u, i, 2'b00, w, ~w, d};
		do @(posedge ref_clk); while (wreq !== 1'b0);
		q = rdata;
		{wr, rd} <= 2'b00;
	endtask
	task automatic pulse(input int k, input logic [2:0] v);
		@(posedge ref_clk);
		pls[k] <= v;
		@(posedge ref_clk);
		pls[k] <= 3'h0;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic settle;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog: the whole sequence needs about 4900 cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		mismatches++;
		tally_and_finish;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, rd, wr, io_tick, pll_tick, addr, wdat, gen_a, gen_b, down, hen} = '0;
		pls = '{default: 3'h0};
		{mismatches, n_compared} = '0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int u = 0; u < 3; u++) for (int i = 0; i < 3; i++) begin
			bus(1'b0, u[1:0], i[3:0], 8'h00);
			`CHK("reg reset", 32'h0, q)
		end
		`CHK("cmp reset", 156'h0, {csa, cra, csb, crb})
		// Split compare writes: high half staged until the low half lands
		bus(1'b1, 2'h1, 4'h3, 8'hfb);
		settle;
		`CHK("sa staged", 12'h0, csa[23:12])
		bus(1'b1, 2'h1, 4'h4, 8'h12);
		bus(1'b1, 2'h0, 4'h9, 8'hc5);
		bus(1'b1, 2'h0, 4'ha, 8'h3e);
		settle;
		`CHK("sa", 12'hb12, csa[23:12])
		`CHK("rb", 16'hc53e, crb[15:0])
		bus(1'b0, 2'h0, 4'ha, 8'h00);
		`CHK("rb read", 32'h0, q)
		bus(1'b0, 2'h3, 4'h0, 8'h00);
		`CHK("unmapped", 32'h0, q)
		// Pin ownership and output selectors of unit 2
		bus(1'b1, 2'h2, 4'h2, 8'hcf);
		{gen_a, gen_b} <= {3'b101, 3'b010};
		settle;
		`CHK("pins on", 4'hf, {pen0[2], pen1[2], pen2, pen3})
		`CHK("out01", {gen_a, gen_b}, {out0, out1})
		`CHK("out23 swap", 2'b01, {out2, out3})
		bus(1'b1, 2'h2, 4'h2, 8'h00);
		settle;
		`CHK("pins off", 4'h0, {pen0[2], pen1[2], pen2, pen3})
		`CHK("out23", 2'b10, {out2, out3})
		// Run chain; unit 1 is master first, then unit 0 with units 1 and 2 as slaves
		bus(1'b1, 2'h1, 4'h0, 8'h05);
		bus(1'b1, 2'h2, 4'h0, 8'h04);
		@(negedge ref_clk);
		`CHK("run over autorun", 3'b110, run)
		bus(1'b1, 2'h1, 4'h0, 8'h04);
		@(negedge ref_clk);
		`CHK("chain stop", 3'b000, run)
		bus(1'b1, 2'h0, 4'h0, 8'h01);
		@(negedge ref_clk);
		`CHK("start together", 3'b111, run)
		pulse(4, 3'b100);
		`CHK("local fault", 3'b111, run)
		pulse(9, 3'b100);
		`CHK("halt disabled", 3'b111, run)
		bus(1'b0, 2'h0, 4'hd, 8'h00);
		`CHK("status", 32'h1, q)
		hen <= 3'b100;
		pulse(9, 3'b100);
		`CHK("halt chain", 3'b000, run)
		bus(1'b0, 2'h0, 4'h0, 8'h00);
		`CHK("master run bit", 32'h0, q)
		// Clock source and prescaler; both sources tick, only the chosen one counts
		for (int s = 0; s < 2; s++) for (int p = 0; p < 4; p++) begin
			bus(1'b1, 2'h0, 4'h1, {6'h0, s[0], 1'b0});
			bus(1'b1, 2'h0, 4'h0, {p[1:0], 6'h01});
			kc = kc_now;
			for (int n = 0; n < 512; n++) begin
				@(posedge ref_clk);
				{io_tick, pll_tick} <= {(n < 256) ^ s[0], (n >= 256) ^ s[0]};
			end
			@(posedge ref_clk);
			{io_tick, pll_tick} <= 2'b00;
			settle;
			`CHK("ticks", 256 >> sh[p], kc_now - kc)
			bus(1'b1, 2'h0, 4'h0, 8'h00);
		end
		// Converter trigger codes, ramp mode then centred mode with RA kept at one
		bus(1'b1, 2'h0, 4'h0, 8'h01);
		bus(1'b1, 2'h0, 4'h5, 8'h00);
		bus(1'b1, 2'h0, 4'h6, 8'h01);
		for (int m = 0; m < 2; m++) for (int c = 0; c < 4; c++) begin
			bus(1'b1, 2'h0, 4'h1, m ? 8'h18 : 8'h00);
			bus(1'b1, 2'h0, 4'h2, {2'h0, c[1:0], 4'h0});
			for (int d = 0; d < 2; d++) for (int k = 0; k < 6; k++) begin
				@(posedge ref_clk);
				down <= {2'h0, d[0]};
				tc = tc_now;
				pulse(k, 3'b001);
				e = m ? (k == 1 && ((c == 0 && d == 1) || (c == 1 && d == 0))) : (k < 4 ? k == c : (k == 4 ? c == 1 : c == 3));
				`CHK("trigger", e, tc_now - tc)
			end
		end
		// Interrupt flags, enables and vector order
		bus(1'b1, 2'h0, 4'hc, 8'h03);
		bus(1'b1, 2'h2, 4'hc, 8'h03);
		bus(1'b1, 2'h0, 4'hb, 8'h03);
		pulse(3, 3'b001);
		`CHK("ec vector", 6'h20, irq)
		pulse(7, 3'b001);
		`CHK("capture_irq vector", 6'h30, irq)
		bus(1'b1, 2'h0, 4'hc, 8'h03);
		settle;
		`CHK("flags cleared", 6'h00, irq)
		pulse(8, 3'b100);
		`CHK("masked", 6'h00, irq)
		bus(1'b1, 2'h2, 4'hb, 8'h02);
		settle;
		`CHK("held flag", 6'h01, irq)
		bus(1'b1, 2'h2, 4'hc, 8'h02);
		bus(1'b1, 2'h1, 4'hb, 8'h02);
		for (int k = 6; k < 9; k++) begin
			pulse(k, 3'b010);
			`CHK("capture_irq source", 6'h04, irq)
			bus(1'b1, 2'h1, 4'hc, 8'h02);
			settle;
			`CHK("capture_irq clear", 6'h00, irq)
		end
		tally_and_finish;
	end
endmodule
